// ### inc/espt_pkg.sv
// Constants for the peak, limit and trim register block of the sensor.
// Assumes an 8-bit register port driven by a serial slave engine on clk.
package espt_pkg;

  // Register offsets
  localparam logic [7:0] ESPT_ADDR_RES_LO     = 8'h00;
  localparam logic [7:0] ESPT_ADDR_RES_TOP    = 8'h03;
  localparam logic [7:0] ESPT_ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ESPT_ADDR_TEMP_PEAK  = 8'h05;
  localparam logic [7:0] ESPT_ADDR_HUM_PEAK   = 8'h06;
  localparam logic [7:0] ESPT_ADDR_GATE       = 8'h07;
  localparam logic [7:0] ESPT_ADDR_TEMP_TRIM  = 8'h08;
  localparam logic [7:0] ESPT_ADDR_HUM_TRIM   = 8'h09;
  localparam logic [7:0] ESPT_ADDR_TEMP_UPPER = 8'h0a;
  localparam logic [7:0] ESPT_ADDR_TEMP_LOWER = 8'h0b;
  localparam logic [7:0] ESPT_ADDR_HUM_UPPER  = 8'h0c;
  localparam logic [7:0] ESPT_ADDR_HUM_LOWER  = 8'h0d;

  // Bit positions shared by the gate and status registers
  localparam int ESPT_BIT_DONE       = 7;
  localparam int ESPT_BIT_TEMP_UPPER = 6;
  localparam int ESPT_BIT_TEMP_LOWER = 5;
  localparam int ESPT_BIT_HUM_UPPER  = 4;
  localparam int ESPT_BIT_HUM_LOWER  = 3;
  localparam int ESPT_FIELD_LSB      = 3;

  // Trim bit 0 weighs 64 result LSBs
  localparam int ESPT_TRIM_SHIFT = 6;

  // Reset values
  localparam logic [7:0] ESPT_RST_PEAK  = 8'h00;
  localparam logic [4:0] ESPT_RST_GATE  = 5'h00;
  localparam logic [7:0] ESPT_RST_TRIM  = 8'h00;
  localparam logic [7:0] ESPT_RST_UPPER = 8'hff;
  localparam logic [7:0] ESPT_RST_LOWER = 8'h00;
  localparam logic [7:0] ESPT_RD_NONE   = 8'h00;

  typedef struct packed {
    logic [7:0]  temp_peak;
    logic [7:0]  hum_peak;
    logic [4:0]  gate;
    logic [7:0]  temp_trim;
    logic [7:0]  hum_trim;
    logic [7:0]  temp_upper;
    logic [7:0]  temp_lower;
    logic [7:0]  hum_upper;
    logic [7:0]  hum_lower;
    logic [4:0]  flags;
    logic [3:0]  live;
    logic [15:0] temp_result;
    logic [15:0] hum_result;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        hit;
  } espt_state_type;

  localparam espt_state_type ESPT_RESET_STATE = '{
    temp_peak:   ESPT_RST_PEAK,
    hum_peak:    ESPT_RST_PEAK,
    gate:        ESPT_RST_GATE,
    temp_trim:   ESPT_RST_TRIM,
    hum_trim:    ESPT_RST_TRIM,
    temp_upper:  ESPT_RST_UPPER,
    temp_lower:  ESPT_RST_LOWER,
    hum_upper:   ESPT_RST_UPPER,
    hum_lower:   ESPT_RST_LOWER,
    flags:       5'h00,
    live:        4'h0,
    temp_result: 16'h0000,
    hum_result:  16'h0000,
    rdata:       ESPT_RD_NONE,
    rvalid:      1'b0,
    hit:         1'b0
  };

endpackage

// ### logic/espt_regs.sv
// Peak detectors, trims, alarm limits, status flags and alert pin of the sensor.
// Assumes conversion results and register accesses arrive on clk, one-cycle strobes.

// Overview of operation
// RULE1: Temperature peak at 0x05 keeps highest converted temperature upper byte.
// RULE2: Host may write temperature peak; zero erases it and tracking restarts.
// RULE3: Humidity peak at 0x06 keeps highest converted humidity upper byte.
// RULE4: Host may write humidity peak; writing zero erases the recorded peak.
// RULE5: Both peaks clear at power-up and on soft reset.
// RULE6: Temperature peak code over 256 times 165 minus 40 is Celsius.
// RULE7: Humidity peak code times 100 over 256 is percent humidity.
// RULE8: Gate bit 7 at 0x07 enables the conversion-done alert; resets to zero.
// RULE9: Gate bits 6..3 disable temperature/humidity upper/lower alerts when one.
// RULE10: Temperature trim at 0x08 is added to every converted temperature.
// RULE11: Trim bits weigh -20.62 down to 0.16 degrees; bit 7 negative.
// RULE12: Humidity trim at 0x09 is added to every converted humidity.
// RULE13: Temperature upper limit at 0x0a, read-write, resets to all ones.
// RULE14: Temperature lower limit at 0x0b, read-write, resets to zero.
// RULE15: Humidity upper limit at 0x0c, read-write, resets to all ones.
// RULE16: Humidity lower limit at 0x0d, read-write, resets to zero.
// RULE17: Temperature limits use the same scale as the temperature peak.
// RULE18: Humidity limits use the humidity peak scale.
// RULE19: Limit flags set when exceeded; reading status register clears them.
// RULE20: Conversion-done flag sets when any conversion finishes.
// RULE21: Alert pin follows the flags, shaped by pin enable, polarity, mode.
// RULE22: Soft reset returns every register here to its reset value.
// RULE23: Upper result byte compared with limits; flag set only when unmasked.
// RULE24: Gate bits 2..0 read zero and ignore writes.
// RULE25: A peak is replaced only by a strictly greater new code.
module espt_regs
  import espt_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        software_reset_bit,
  // Register port from the serial slave engine
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output      logic [7:0]  reg_rdata,
  output      logic        reg_rvalid,
  output      logic        reg_hit,
  // Raw conversion results
  input  wire logic        temp_done,
  input  wire logic [15:0] temp_raw,
  input  wire logic        hum_done,
  input  wire logic [15:0] hum_raw,
  // Trimmed results for the result registers
  output      logic [15:0] temp_result,
  output      logic [15:0] hum_result,
  // Alert pin configuration
  input  wire logic        pin_enable,
  input  wire logic        pin_active_high,
  input  wire logic        pin_comparator_mode,
  // Alert pin and status view
  output      logic        alert_output_pin,
  output      logic        alert_output_pin_oe_n,
  output      logic [4:0]  status_flags
);
  import espt_pkg::*;

  espt_state_type s_q;
  espt_state_type s_d;

  // Signed trim placed at its weight; saturation keeps a large trim from wrapping
  function automatic logic [15:0] espt_trim_add(input logic [15:0] raw,
                                                input logic [7:0]  trim);
    logic signed [17:0] sum;
    sum = $signed({2'b00, raw}) +
          $signed({{4{trim[7]}}, trim, {ESPT_TRIM_SHIFT{1'b0}}}); // RULE11
    if (sum[17])
      espt_trim_add = 16'h0000;
    else if (sum[16])
      espt_trim_add = 16'hffff;
    else
      espt_trim_add = sum[15:0];
  endfunction

  logic [15:0] temp_adj;
  logic [15:0] hum_adj;
  logic [7:0]  temp_byte;
  logic [7:0]  hum_byte;
  logic        wr_hit;
  logic        status_read;
  logic [4:0]  set_flags;
  logic [3:0]  exceed;
  logic        alert_any;

  always_comb
  begin
    temp_adj  = espt_trim_add(temp_raw, s_q.temp_trim); // RULE10
    hum_adj   = espt_trim_add(hum_raw, s_q.hum_trim);   // RULE12
    temp_byte = temp_adj[15:8]; // RULE6 RULE17
    hum_byte  = hum_adj[15:8];  // RULE7 RULE18
  end

  // Limit comparisons on the trimmed upper byte
  always_comb
  begin
    exceed = 4'h0;
    exceed[ESPT_BIT_TEMP_UPPER - ESPT_FIELD_LSB] = temp_byte > s_q.temp_upper; // RULE23
    exceed[ESPT_BIT_TEMP_LOWER - ESPT_FIELD_LSB] = temp_byte < s_q.temp_lower; // RULE23
    exceed[ESPT_BIT_HUM_UPPER - ESPT_FIELD_LSB]  = hum_byte > s_q.hum_upper;   // RULE23
    exceed[ESPT_BIT_HUM_LOWER - ESPT_FIELD_LSB]  = hum_byte < s_q.hum_lower;   // RULE23
  end

  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    wr_hit = 1'b0;
    status_read = reg_rd && (reg_addr == ESPT_ADDR_STATUS);
    set_flags = 5'h00;

    // Host writes
    if (reg_wr)
    begin
      wr_hit = 1'b1;
      case (reg_addr)
        ESPT_ADDR_TEMP_PEAK:  s_d.temp_peak = reg_wdata; // RULE2
        ESPT_ADDR_HUM_PEAK:   s_d.hum_peak = reg_wdata;  // RULE4
        ESPT_ADDR_GATE:       s_d.gate = reg_wdata[7:ESPT_FIELD_LSB]; // RULE8 RULE9 RULE24
        ESPT_ADDR_TEMP_TRIM:  s_d.temp_trim = reg_wdata;  // RULE10
        ESPT_ADDR_HUM_TRIM:   s_d.hum_trim = reg_wdata;   // RULE12
        ESPT_ADDR_TEMP_UPPER: s_d.temp_upper = reg_wdata; // RULE13
        ESPT_ADDR_TEMP_LOWER: s_d.temp_lower = reg_wdata; // RULE14
        ESPT_ADDR_HUM_UPPER:  s_d.hum_upper = reg_wdata;  // RULE15
        ESPT_ADDR_HUM_LOWER:  s_d.hum_lower = reg_wdata;  // RULE16
        default:              wr_hit = 1'b0;
      endcase
    end

    // Peaks compare against the post-write value so an erase restarts tracking
    if (temp_done)
    begin
      s_d.temp_result = temp_adj;
      if (temp_byte > s_d.temp_peak) // RULE1 RULE25
        s_d.temp_peak = temp_byte;
      set_flags[ESPT_BIT_DONE - ESPT_FIELD_LSB] = 1'b1; // RULE20
      set_flags[ESPT_BIT_TEMP_UPPER - ESPT_FIELD_LSB] =
        exceed[ESPT_BIT_TEMP_UPPER - ESPT_FIELD_LSB] &
        ~s_q.gate[ESPT_BIT_TEMP_UPPER - ESPT_FIELD_LSB]; // RULE9 RULE23
      set_flags[ESPT_BIT_TEMP_LOWER - ESPT_FIELD_LSB] =
        exceed[ESPT_BIT_TEMP_LOWER - ESPT_FIELD_LSB] &
        ~s_q.gate[ESPT_BIT_TEMP_LOWER - ESPT_FIELD_LSB]; // RULE9 RULE23
      s_d.live[ESPT_BIT_TEMP_UPPER - ESPT_FIELD_LSB] =
        set_flags[ESPT_BIT_TEMP_UPPER - ESPT_FIELD_LSB];
      s_d.live[ESPT_BIT_TEMP_LOWER - ESPT_FIELD_LSB] =
        set_flags[ESPT_BIT_TEMP_LOWER - ESPT_FIELD_LSB];
    end
    if (hum_done)
    begin
      s_d.hum_result = hum_adj;
      if (hum_byte > s_d.hum_peak) // RULE3 RULE25
        s_d.hum_peak = hum_byte;
      set_flags[ESPT_BIT_DONE - ESPT_FIELD_LSB] = 1'b1; // RULE20
      set_flags[ESPT_BIT_HUM_UPPER - ESPT_FIELD_LSB] =
        exceed[ESPT_BIT_HUM_UPPER - ESPT_FIELD_LSB] &
        ~s_q.gate[ESPT_BIT_HUM_UPPER - ESPT_FIELD_LSB]; // RULE9 RULE23
      set_flags[ESPT_BIT_HUM_LOWER - ESPT_FIELD_LSB] =
        exceed[ESPT_BIT_HUM_LOWER - ESPT_FIELD_LSB] &
        ~s_q.gate[ESPT_BIT_HUM_LOWER - ESPT_FIELD_LSB]; // RULE9 RULE23
      s_d.live[ESPT_BIT_HUM_UPPER - ESPT_FIELD_LSB] =
        set_flags[ESPT_BIT_HUM_UPPER - ESPT_FIELD_LSB];
      s_d.live[ESPT_BIT_HUM_LOWER - ESPT_FIELD_LSB] =
        set_flags[ESPT_BIT_HUM_LOWER - ESPT_FIELD_LSB];
    end

    // Read data; a status read clears the flags
    if (reg_rd)
    begin
      s_d.rvalid = 1'b1;
      s_d.hit = 1'b1;
      case (reg_addr)
        ESPT_ADDR_STATUS:     s_d.rdata = {s_q.flags, 3'b000};
        ESPT_ADDR_TEMP_PEAK:  s_d.rdata = s_q.temp_peak;
        ESPT_ADDR_HUM_PEAK:   s_d.rdata = s_q.hum_peak;
        ESPT_ADDR_GATE:       s_d.rdata = {s_q.gate, 3'b000}; // RULE24
        ESPT_ADDR_TEMP_TRIM:  s_d.rdata = s_q.temp_trim;
        ESPT_ADDR_HUM_TRIM:   s_d.rdata = s_q.hum_trim;
        ESPT_ADDR_TEMP_UPPER: s_d.rdata = s_q.temp_upper;
        ESPT_ADDR_TEMP_LOWER: s_d.rdata = s_q.temp_lower;
        ESPT_ADDR_HUM_UPPER:  s_d.rdata = s_q.hum_upper;
        ESPT_ADDR_HUM_LOWER:  s_d.rdata = s_q.hum_lower;
        default:
        begin
          s_d.rdata = ESPT_RD_NONE;
          s_d.hit = 1'b0;
        end
      endcase
    end
    else if (reg_wr)
    begin
      s_d.hit = wr_hit;
    end

    // Clears first, sets last, so an event in the clearing cycle survives
    if (status_read)
      s_d.flags = 5'h00; // RULE19
    // Result offsets start at zero, so only the top bound needs a compare
    if (reg_rd && (reg_addr <= ESPT_ADDR_RES_TOP))
      s_d.flags[ESPT_BIT_DONE - ESPT_FIELD_LSB] = 1'b0;
    s_d.flags = s_d.flags | set_flags; // RULE19 RULE20

    if (software_reset_bit)
      s_d = ESPT_RESET_STATE; // RULE5 RULE22
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= ESPT_RESET_STATE; // RULE5
    else
      s_q <= s_d;
  end

  // Level mode follows latched flags; comparator mode follows the latest comparison
  always_comb
  begin
    alert_any = s_q.flags[ESPT_BIT_DONE - ESPT_FIELD_LSB] &
                s_q.gate[ESPT_BIT_DONE - ESPT_FIELD_LSB]; // RULE8
    if (pin_comparator_mode)
      alert_any = alert_any | (|s_q.live);
    else
      alert_any = alert_any | (|s_q.flags[3:0]); // RULE21
  end

  assign alert_output_pin      = pin_active_high ? alert_any : ~alert_any; // RULE21
  assign alert_output_pin_oe_n = ~pin_enable;
  assign reg_rdata             = s_q.rdata;
  assign reg_rvalid            = s_q.rvalid;
  assign reg_hit               = s_q.hit;
  assign temp_result           = s_q.temp_result;
  assign hum_result            = s_q.hum_result;
  assign status_flags          = s_q.flags;

endmodule

// ### testbench/espt_regs_props.sv
// Port checks for the sensor peak, limit and trim block.
// Assumes one clk domain with the block's synchronous rst.
module espt_regs_props
  import espt_pkg::*;
(
  // Clock and resets
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       software_reset_bit,
  // Inputs seen
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic       temp_done,
  input wire logic       hum_done,
  input wire logic       pin_enable,
  input wire logic       pin_active_high,
  input wire logic       pin_comparator_mode,
  // Outputs seen
  input wire logic       reg_rvalid,
  input wire logic       reg_hit,
  input wire logic       alert_output_pin,
  input wire logic       alert_output_pin_oe_n,
  input wire logic [4:0] status_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rvalid; !rst |=> reg_rvalid == $past(reg_rd & !software_reset_bit); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid off");
  property p_mapped; reg_rd && !software_reset_bit && reg_addr >= ESPT_ADDR_TEMP_PEAK
    && reg_addr <= ESPT_ADDR_HUM_LOWER |=> reg_hit; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped read missed");
  property p_oe; alert_output_pin_oe_n == !pin_enable; endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_done; (temp_done || hum_done) && !software_reset_bit |=> status_flags[4]; endproperty
  a_done: assert property (p_done) else $error("done flag not set");
  property p_clear; reg_rd && reg_addr == ESPT_ADDR_STATUS && !temp_done && !hum_done
    && !software_reset_bit |=> status_flags == 5'h00 && reg_hit; endproperty
  a_clear: assert property (p_clear) else $error("status read kept flags");
  property p_hold; !reg_rd && !temp_done && !hum_done && !software_reset_bit
    |=> $stable(status_flags); endproperty
  a_hold: assert property (p_hold) else $error("flags moved idle");
  property p_soft; software_reset_bit |=> status_flags == 5'h00 && !reg_hit && !reg_rvalid;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset incomplete");
  property p_pin; !pin_comparator_mode && status_flags == 5'h00
    |-> alert_output_pin == !pin_active_high; endproperty
  a_pin: assert property (p_pin) else $error("pin active without flags");
  c_status: cover property (reg_rd && reg_addr == ESPT_ADDR_STATUS);
  c_soft: cover property (software_reset_bit);
  c_pin: cover property (alert_output_pin == pin_active_high);
  c_cmp: cover property (pin_comparator_mode && alert_output_pin == pin_active_high);
endmodule

bind espt_regs espt_regs_props u_props (.clk(clk), .rst(rst),
  .software_reset_bit(software_reset_bit), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .temp_done(temp_done), .hum_done(hum_done), .pin_enable(pin_enable),
  .pin_active_high(pin_active_high), .pin_comparator_mode(pin_comparator_mode),
  .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .alert_output_pin(alert_output_pin),
  .alert_output_pin_oe_n(alert_output_pin_oe_n), .status_flags(status_flags));

// ### testbench/espt_host.sv
// Register master standing in for the serial engine on the host side.
// Assumes strobes change at the falling clock edge.
module espt_host
(
  // Clock
  input wire logic        clk,
  // Register port
  output     logic [7:0]  reg_addr,
  output     logic        reg_wr,
  output     logic        reg_rd,
  output     logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Idle lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
endmodule

// ### testbench/espt_regs_tb.sv
// Self-checking bench for the sensor peak, limit and trim registers.
// Assumes the host model drives the register port at falling edges.
module espt_regs_tb
  import espt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, software_reset_bit, temp_done, hum_done, reg_wr, reg_rd, reg_rvalid, reg_hit;
  logic pin_enable, pin_active_high, pin_comparator_mode, alert_output_pin, alert_output_pin_oe_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] temp_raw, hum_raw, temp_result, hum_result;
  logic [4:0] status_flags;
  int mismatches;
  int comparisons;
  espt_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  espt_regs u_dut (.clk(clk), .rst(rst), .software_reset_bit(software_reset_bit),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .temp_done(temp_done),
    .temp_raw(temp_raw), .hum_done(hum_done), .hum_raw(hum_raw), .temp_result(temp_result),
    .hum_result(hum_result), .pin_enable(pin_enable), .pin_active_high(pin_active_high),
    .pin_comparator_mode(pin_comparator_mode), .alert_output_pin(alert_output_pin),
    .alert_output_pin_oe_n(alert_output_pin_oe_n), .status_flags(status_flags));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk("read data", {a, e}, {a, d});
  endtask
  task automatic conv(input logic t, input logic [15:0] v);
    @(negedge clk);
    temp_done = t;
    hum_done = !t;
    temp_raw = v;
    hum_raw = v;
    @(negedge clk);
    temp_done = 1'b0;
    hum_done = 1'b0;
    temp_raw = ~v;
    hum_raw = ~v;
  endtask
  task automatic t_reset_vals;
    rchk(8'h05, 8'h00);
    rchk(8'h06, 8'h00);
    rchk(8'h07, 8'h00);
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h00);
    rchk(8'h0a, 8'hff);
    rchk(8'h0b, 8'h00);
    rchk(8'h0c, 8'hff);
    rchk(8'h0d, 8'h00);
  endtask
  task automatic t_rw_soft;
    for (int a = 8'h05; a <= 8'h0d; a++)
      u_host.wr(8'(a), 8'(a) ^ 8'ha5);
    for (int a = 8'h05; a <= 8'h0d; a++)
      rchk(8'(a), (8'(a) ^ 8'ha5) & (a == 7 ? 8'hf8 : 8'hff));
    @(negedge clk);
    software_reset_bit = 1'b1;
    @(negedge clk);
    software_reset_bit = 1'b0;
    t_reset_vals();
  endtask
  task automatic t_peak;
    conv(1'b1, 16'h9000);
    conv(1'b1, 16'h8f00);
    rchk(8'h05, 8'h90);
    u_host.wr(8'h05, 8'h00);
    conv(1'b1, 16'h4000);
    rchk(8'h05, 8'h40);
    conv(1'b0, 16'h5500);
    rchk(8'h06, 8'h55);
    u_host.wr(8'h06, 8'h00);
    rchk(8'h06, 8'h00);
  endtask
  task automatic t_trim;
    u_host.wr(8'h08, 8'h01);
    conv(1'b1, 16'h4000);
    chk("temp result", 16'h4040, temp_result);
    u_host.wr(8'h08, 8'h80);
    conv(1'b1, 16'h4000);
    chk("temp result", 16'h2000, temp_result);
    u_host.wr(8'h09, 8'h02);
    conv(1'b0, 16'h1000);
    chk("hum result", 16'h1080, hum_result);
    u_host.wr(8'h08, 8'h00);
  endtask
  task automatic t_flags;
    u_host.wr(8'h0a, 8'h80);
    rchk(8'h04, 8'h80);
    conv(1'b1, 16'ha000);
    rchk(8'h04, 8'hc0);
    rchk(8'h04, 8'h00);
    u_host.wr(8'h07, 8'h40);
    conv(1'b1, 16'ha000);
    rchk(8'h04, 8'h80);
    u_host.wr(8'h07, 8'h80);
    conv(1'b1, 16'h5000);
    chk("alert pin", 16'h0001, {15'h0, alert_output_pin});
    u_host.wr(8'h07, 8'h00);
    chk("alert pin", 16'h0000, {15'h0, alert_output_pin});
  endtask
  // Comparator mode, active low, pin released; humidity trim is still 0x02
  task automatic t_pin;
    @(negedge clk);
    {pin_enable, pin_active_high, pin_comparator_mode} = 3'h1;
    u_host.wr(8'h0d, 8'h40);
    conv(1'b0, 16'h2000);
    chk("alert pin", 16'h0000, {15'h0, alert_output_pin});
    chk("pin enable", 16'h0001, {15'h0, alert_output_pin_oe_n});
    conv(1'b0, 16'h6000);
    chk("alert pin", 16'h0001, {15'h0, alert_output_pin});
    rchk(8'h04, 8'h88);
    u_host.wr(8'h0b, 8'h30);
    u_host.wr(8'h0c, 8'h70);
    conv(1'b1, 16'h2000);
    conv(1'b0, 16'h7f00);
    rchk(8'h04, 8'hb0);
    {pin_enable, pin_active_high, pin_comparator_mode} = 3'h6;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200000;
    mismatches++;
    wrap_up();
  end
  initial
  begin
    {rst, software_reset_bit, temp_done, hum_done} = 4'hc;
    {temp_raw, hum_raw} = 32'h0000_0000;
    {pin_enable, pin_active_high, pin_comparator_mode} = 3'h6;
    // Two full rising edges in reset, released at a falling edge
    repeat (2) @(posedge clk);
    @(negedge clk);
    {rst, software_reset_bit, temp_done, hum_done} = 4'h0;
    t_reset_vals();
    t_rw_soft();
    t_peak();
    t_trim();
    t_flags();
    t_pin();
    wrap_up();
  end
endmodule
